// ===== pfp_host.sv
// Purpose: host controller that loads pages, issues command sequences and polls for completion
// Assumes: pin inputs synchronous to i_clk; a single command is taken while o_ready is high
// Notes:   the data pins are three signals; the output enable is low while driving
//
// How it works
// - every byte of one page load uses the same upper address bits
// - output gate stays high whenever write strobe and chip select are low
// - next byte strobe starts well inside 150 us of the previous rising edge
// - protection sequences are followed by the full 64 data bytes of a page
// - erase done when a complement poll read returns all ones
// - after the six erase bytes, no loads until erase completes
// - with i_use_toggle set, completion is seen only when the toggle bit stops changing
// - status reads keep one constant address
// - command bytes are hex data on the data pins, addresses on the address pins
`timescale 1ns/10ps
`default_nettype none
module pfp_host #(
  parameter int unsigned WRITE_TIMEOUT_CYC = pfp_pkg::WRITE_CYC + pfp_pkg::WRITE_CYC / 4,
  parameter logic [14:0] CMD_A1 = 15'h5555,
  parameter logic [14:0] CMD_A2 = 15'h2AAA,
  parameter logic [7:0]  CMD_D1 = 8'hAA,
  parameter logic [7:0]  CMD_D2 = 8'h55,
  parameter logic [7:0]  CMD_EN = 8'hA0,
  parameter logic [7:0]  CMD_DIS1 = 8'h80,
  parameter logic [7:0]  CMD_DIS2 = 8'h20,
  parameter logic [7:0]  CMD_ER1 = 8'h80,
  parameter logic [7:0]  CMD_ER2 = 8'h10
)(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // command port
  input  wire logic        i_start,
  input  wire logic [2:0]  i_op,
  input  wire logic        i_use_toggle,
  input  wire logic [8:0]  i_page,
  output logic             o_ready,
  output logic             o_done,
  output logic             o_timeout,
  // page data request: byte index out, byte value in
  output logic [5:0]       o_byte_idx,
  input  wire logic [7:0]  i_byte_data,
  // flash pins
  output logic [14:0]      o_addr,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic [7:0]       o_dq,
  output logic             o_dq_oe_n,
  input  wire logic [7:0]  i_dq
);
  // ---------------------------------------------------------------
  // operations and states
  // ---------------------------------------------------------------
  // op: 0 plain program, 1 protected program, 2 protect enable, 3 protect disable, 4 chip erase
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_PULSE = 6'b000100,
    ST_HIGH  = 6'b001000,
    ST_READ  = 6'b010000,
    ST_GAP   = 6'b100000
  } pfp_state_e;

  pfp_state_e              state_reg, state_next;
  logic [23:0]             cnt_reg, cnt_next;
  logic [23:0]             wait_reg, wait_next;
  logic [3:0]              cmd_idx_reg, cmd_idx_next;
  logic [6:0]              byte_reg, byte_next;
  logic [2:0]              op_reg, op_next;
  logic                    tog_reg, tog_next;
  logic [8:0]              page_reg, page_next;
  logic                    first_reg, first_next;
  logic [7:0]              prev_reg, prev_next;
  logic [7:0]              last_reg, last_next;
  logic                    done_reg, done_next;
  logic                    tmo_reg, tmo_next;
  logic [14:0]             addr_reg, addr_next;
  logic [7:0]              dq_reg, dq_next;
  logic                    ce_n_reg, ce_n_next;
  logic                    oe_n_reg, oe_n_next;
  logic                    we_n_reg, we_n_next;
  logic                    drv_reg, drv_next;
  logic [3:0]              cmd_len;
  logic [14:0]             cmd_addr;
  logic [7:0]              cmd_data;
  logic                    in_cmd;

  // number of command bytes that lead each operation
  function automatic logic [3:0] seq_len(input logic [2:0] op);
    unique case (op)
      3'd1, 3'd2: seq_len = 4'd3;
      3'd3, 3'd4: seq_len = 4'd6;
      default:    seq_len = 4'd0;
    endcase
  endfunction

  // address/data of command byte k; pattern A1 A2 A1 (A1 A2 A1)
  function automatic logic [14:0] seq_addr(input logic [3:0] k);
    seq_addr = (k == 4'd1 || k == 4'd4) ? CMD_A2 : CMD_A1;
  endfunction

  always_comb
  begin
    cmd_len  = seq_len(op_reg);
    in_cmd   = ({1'b0, cmd_idx_reg} < {1'b0, cmd_len});
    cmd_addr = seq_addr(cmd_idx_reg);
    unique case (cmd_idx_reg)
      4'd0, 4'd3: cmd_data = CMD_D1;
      4'd1, 4'd4: cmd_data = CMD_D2;
      4'd2:       cmd_data = (op_reg == 3'd1 || op_reg == 3'd2) ? CMD_EN : (op_reg == 3'd3 ? CMD_DIS1 : CMD_ER1);
      default:    cmd_data = (op_reg == 3'd3) ? CMD_DIS2 : CMD_ER2;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    wait_next    = wait_reg;
    cmd_idx_next = cmd_idx_reg;
    byte_next    = byte_reg;
    op_next      = op_reg;
    tog_next     = tog_reg;
    page_next    = page_reg;
    first_next   = first_reg;
    prev_next    = prev_reg;
    last_next    = last_reg;
    done_next    = 1'b0;
    tmo_next     = 1'b0;
    addr_next    = addr_reg;
    dq_next      = dq_reg;
    ce_n_next    = ce_n_reg;
    oe_n_next    = oe_n_reg;
    we_n_next    = we_n_reg;
    drv_next     = drv_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        drv_next  = 1'b0;
        if (i_start)
        begin
          op_next      = i_op;
          tog_next     = i_use_toggle;
          page_next    = i_page;
          cmd_idx_next = 4'd0;
          byte_next    = 7'd0;
          cnt_next     = 24'd0;
          state_next   = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // oe high before strobes go low
        oe_n_next = 1'b1;
        ce_n_next = 1'b0;
        drv_next  = 1'b1;
        if (in_cmd)
        begin
          addr_next = cmd_addr;
          dq_next   = cmd_data;
        end
        else
        begin
          addr_next = {page_reg, byte_reg[5:0]};
          dq_next   = i_byte_data;
        end
        cnt_next = cnt_reg + 24'd1;
        if (cnt_reg + 24'd1 >= 24'(pfp_pkg::SETUP_CYC))
        begin
          cnt_next   = 24'd0;
          last_next  = dq_next;
          state_next = ST_PULSE;
        end
      end
      ST_PULSE:
      begin
        // address held through the whole low pulse
        // we_n falls one cycle into the state, so one extra count keeps the full width
        we_n_next = 1'b0;
        cnt_next  = cnt_reg + 24'd1;
        if (cnt_reg >= 24'(pfp_pkg::PULSE_CYC))
        begin
          cnt_next   = 24'd0;
          we_n_next  = 1'b1;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        cnt_next = cnt_reg + 24'd1;
        if (cnt_reg + 24'd1 >= 24'(pfp_pkg::HIGH_CYC))
        begin
          cnt_next = 24'd0;
          if (in_cmd)
            cmd_idx_next = cmd_idx_reg + 4'd1;
          else
            byte_next = byte_reg + 7'd1;
          // erase: stop loading after the six bytes; others load a full page
          if ((op_reg == 3'd4 && cmd_idx_reg == 4'd5) ||
              (!in_cmd && byte_reg == 7'(pfp_pkg::PAGE_BYTES - 1)))
          begin
            ce_n_next  = 1'b1;
            drv_next   = 1'b0;
            wait_next  = 24'd0;
            first_next = 1'b1;
            state_next = ST_GAP;
          end
          else
            state_next = ST_SETUP;
        end
      end
      ST_GAP:
      begin
        // read pulse: ce and oe low, address constant
        wait_next = wait_reg + 24'd1;
        cnt_next  = cnt_reg + 24'd1;
        ce_n_next = 1'b0;
        oe_n_next = 1'b0;
        we_n_next = 1'b1;
        drv_next  = 1'b0;
        addr_next = (op_reg == 3'd4) ? 15'h0000 : {page_reg, 6'h3F};
        if (cnt_reg + 24'd1 >= 24'(pfp_pkg::READ_CYC))
        begin
          cnt_next   = 24'd0;
          state_next = ST_READ;
        end
      end
      ST_READ:
      begin
        // strobes stay high a full pulse width between reads so each is a new read
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        wait_next = wait_reg + 24'd1;
        cnt_next  = cnt_reg + 24'd1;
        if (cnt_reg == 24'd0)
        begin
          prev_next  = i_dq;
          first_next = 1'b0;
          if (tog_reg)
          begin
            if (!first_reg && i_dq[pfp_pkg::TOGGLE_BIT] == prev_reg[pfp_pkg::TOGGLE_BIT])
            begin
              done_next  = 1'b1;
              state_next = ST_IDLE;
            end
          end
          else if (op_reg == 3'd4 ? (i_dq == pfp_pkg::ERASED_BYTE) :
                   (i_dq[pfp_pkg::POLL_BIT] == last_reg[pfp_pkg::POLL_BIT]))
          begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
          if (state_next == ST_READ && wait_reg >= 24'(WRITE_TIMEOUT_CYC))
          begin
            tmo_next   = 1'b1;
            state_next = ST_IDLE;
          end
        end
        if (state_next == ST_READ && cnt_reg + 24'd1 >= 24'(pfp_pkg::PULSE_CYC))
        begin
          cnt_next   = 24'd0;
          state_next = ST_GAP;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 24'd0;
      wait_reg    <= 24'd0;
      cmd_idx_reg <= 4'd0;
      byte_reg    <= 7'd0;
      op_reg      <= 3'd0;
      tog_reg     <= 1'b0;
      page_reg    <= 9'd0;
      first_reg   <= 1'b1;
      prev_reg    <= 8'h00;
      last_reg    <= 8'h00;
      done_reg    <= 1'b0;
      tmo_reg     <= 1'b0;
      addr_reg    <= 15'h0000;
      dq_reg      <= 8'h00;
      ce_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      drv_reg     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      wait_reg    <= wait_next;
      cmd_idx_reg <= cmd_idx_next;
      byte_reg    <= byte_next;
      op_reg      <= op_next;
      tog_reg     <= tog_next;
      page_reg    <= page_next;
      first_reg   <= first_next;
      prev_reg    <= prev_next;
      last_reg    <= last_next;
      done_reg    <= done_next;
      tmo_reg     <= tmo_next;
      addr_reg    <= addr_next;
      dq_reg      <= dq_next;
      ce_n_reg    <= ce_n_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      drv_reg     <= drv_next;
    end
  end

  assign o_ready    = (state_reg == ST_IDLE);
  assign o_done     = done_reg;
  assign o_timeout  = tmo_reg;
  assign o_byte_idx = byte_reg[5:0];
  assign o_addr     = addr_reg;
  assign o_ce_n     = ce_n_reg;
  assign o_oe_n     = oe_n_reg;
  assign o_we_n     = we_n_reg;
  assign o_dq       = dq_reg;
  assign o_dq_oe_n  = ~drv_reg;
endmodule // pfp_host
`default_nettype wire

// ===== pfp_pkg.sv
// Purpose: shared constants for the page flash program controller
// Assumes: 125 MHz clock, 8 ns period
// Notes:   command addresses and data are parameters of the top module
package pfp_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PAGE_BYTES  = 64;
  localparam int unsigned PAGE_LSB    = 6;
  localparam int unsigned POLL_BIT    = 7;
  localparam int unsigned TOGGLE_BIT  = 6;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SETUP_NS      = 50;
  localparam int unsigned PULSE_NS      = 150;
  localparam int unsigned HIGH_NS       = 100;
  localparam int unsigned READ_NS       = 250;
  localparam int unsigned LOAD_GAP_US   = 150;
  localparam int unsigned WRITE_CYC_MS  = 10;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_CYC  = (HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC  = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_GAP_CYC = (LOAD_GAP_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC    = (WRITE_CYC_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W      = 24;
endpackage

// ===== pfp_host_monitor.sv
// Purpose: pin-level checks on the page flash host
// Assumes: one clock, sync active-high reset
// Notes:   bound to every pfp_host instance
`timescale 1ns/10ps
`default_nettype none
module pfp_host_monitor (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // command port
  input wire logic        i_start,
  input wire logic        o_ready,
  input wire logic        o_done,
  input wire logic        o_timeout,
  // flash pins
  input wire logic [14:0] o_addr,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_we_n,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] low_cnt_reg;
  logic [7:0] high_cnt_reg;
  // length of the current write strobe low and gate high phases
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      low_cnt_reg  <= 8'h00;
      high_cnt_reg <= 8'h00;
    end
    else
    begin
      low_cnt_reg  <= o_we_n ? 8'h00 : low_cnt_reg + 8'h01;
      high_cnt_reg <= !o_oe_n ? 8'h00 : (high_cnt_reg == 8'hFF ? high_cnt_reg : high_cnt_reg + 8'h01);
    end
  end
  pulse_len_a: assert property ($rose(o_we_n) |-> low_cnt_reg >= 8'(pfp_pkg::PULSE_CYC)) else $error("low short");
  read_gap_a: assert property ($fell(o_oe_n) |-> high_cnt_reg >= 8'(pfp_pkg::PULSE_CYC)) else $error("gap short");
  gate_high_a: assert property (!o_we_n && !o_ce_n |-> o_oe_n) else $error("gate low in write");
  page_stable_a: assert property (!o_we_n && !$fell(o_we_n) |-> $stable(o_addr)) else $error("addr moved");
  data_held_a: assert property (!o_we_n && !$fell(o_we_n) |-> $stable(o_dq) && !o_dq_oe_n) else $error("data");
  pulse_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*8]) else $error("short strobe");
  read_strobe_a: assert property ($fell(o_oe_n) |-> (!o_oe_n && !o_ce_n && o_dq_oe_n) [*8]) else $error("read");
  poll_addr_a: assert property (!o_oe_n && !$fell(o_oe_n) |-> $stable(o_addr)) else $error("poll addr");
  done_pulse_a: assert property (o_done |=> !o_done && !o_timeout && o_ready) else $error("done pulse");
  start_taken_a: assert property (o_ready && i_start |=> !o_ready [*4]) else $error("start lost");
endmodule // pfp_host_monitor
bind pfp_host pfp_host_monitor mon (.*);
`default_nettype wire

// ===== pfp_flash_model.sv
// Purpose: behavioural page flash device for the host bench
// Assumes: pins sampled on i_clk; window closes GAP_CYC after last load
// Notes:   busy time set by i_busy_cyc
`timescale 1ns/10ps
`default_nettype none
module pfp_flash_model #(
  parameter int GAP_CYC = 100
)(
  // clock and control
  input wire logic        i_clk,
  input wire logic [31:0] i_busy_cyc,
  // flash pins
  input wire logic [14:0] i_addr,
  input wire logic        i_ce_n,
  input wire logic        i_oe_n,
  input wire logic        i_we_n,
  input wire logic [7:0]  i_dq,
  output logic [7:0]      o_dq
);
  localparam logic [22:0] C1 = {15'h5555, 8'hAA};
  localparam logic [22:0] C2 = {15'h2AAA, 8'h55};
  logic [7:0]  mem [0:32767];
  logic [7:0]  pbuf [0:63];
  logic [22:0] hist [$];
  logic [14:0] la;
  logic [8:0]  pg;
  logic [7:0]  last = 0, held = 0;
  logic        wr_q = 0, rd_q = 0, tog = 0, prot = 0, busy = 0, loading = 0, er = 0, en = 0, dis = 0;
  int          gap = 0, tmr = 0, s;
  wire logic   wr = !i_ce_n && !i_we_n && i_oe_n;
  wire logic   rd = !i_ce_n && !i_oe_n && i_we_n;
  function automatic bit six(input logic [7:0] x, y);
    return hist.size() >= 6 && hist[0] == C1 && hist[1] == C2 && hist[2] == {15'h5555, x}
      && hist[3] == C1 && hist[4] == C2 && hist[5] == {15'h5555, y};
  endfunction
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge i_clk)
  begin
    wr_q <= wr;
    rd_q <= rd;
    if (wr && !wr_q) la <= i_addr;
    if (!wr && wr_q && !busy)
    begin
      hist.push_back({la, i_dq});
      last <= i_dq;
      er = 1'b0;
      gap <= 0;
      loading <= 1'b1;
    end
    else if (loading && gap < GAP_CYC) gap <= gap + 1;
    else if (loading)
    begin
      loading <= 1'b0;
      er = six(8'h80, 8'h10);
      dis = six(8'h80, 8'h20);
      en = !dis && !er && hist.size() >= 3 && hist[0] == C1 && hist[1] == C2 && hist[2] == {15'h5555, 8'hA0};
      s = (er || dis) ? 6 : en ? 3 : 0;
      foreach (pbuf[i]) pbuf[i] = 8'hFF;
      for (int k = s; k < hist.size(); k++)
      begin
        pg = hist[k][22:14];
        pbuf[hist[k][13:8]] = hist[k][7:0];
      end
      busy <= er || en || dis || !prot;
      tmr <= 0;
      hist.delete();
    end
    if (busy)
    begin
      tmr <= tmr + 1;
      if (tmr >= int'(i_busy_cyc))
      begin
        busy <= 1'b0;
        if (er) foreach (mem[i]) mem[i] = 8'hFF;
        else foreach (pbuf[i]) mem[{pg, i[5:0]}] = pbuf[i];
        if (en) prot <= 1'b1;
        if (dis) prot <= 1'b0;
      end
    end
    if (rd && !rd_q && (busy || loading)) tog <= ~tog;
    if (rd) held <= o_dq;
  end
  // released bus shows the inverse of the last driven value
  // status shows from the first load on, so polling may start right after loading
  assign o_dq = !rd ? ~held : (busy || loading) ? {er ? 1'b0 : ~last[7], tog, 6'h2A} : mem[i_addr];
endmodule // pfp_flash_model
`default_nettype wire

// ===== pfp_host_tb_top.sv
// Purpose: self-checking bench for the page flash host
// Assumes: 125 MHz clock, model busy time set per scenario
// Notes:   page byte value is index xor a per-test pattern
`timescale 1ns/10ps
`default_nettype none
module pfp_host_tb_top;
  logic        i_clk, i_reset, i_start, i_use_toggle, o_ready, o_done, o_timeout;
  logic        o_ce_n, o_oe_n, o_we_n, o_dq_oe_n;
  logic [2:0]  i_op;
  logic [8:0]  i_page;
  logic [5:0]  o_byte_idx;
  logic [7:0]  i_byte_data, o_dq, i_dq, dev_dq, pat;
  logic [14:0] o_addr;
  logic [31:0] busy_cyc;
  logic [1:0]  res;
  int          err_total = 0, n_compared = 0;
  assign i_byte_data = {2'b00, o_byte_idx} ^ pat;
  assign i_dq = o_dq_oe_n ? dev_dq : o_dq;
  pfp_host #(.WRITE_TIMEOUT_CYC(2000)) uut (.*);
  pfp_flash_model dev (.i_clk(i_clk), .i_busy_cyc(busy_cyc), .i_addr(o_addr), .i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(i_dq), .o_dq(dev_dq));
  initial
  begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run_op(input logic [2:0] op, input logic tg, input logic [8:0] pg);
    int n;
    @(posedge i_clk);
    i_op <= op;
    i_use_toggle <= tg;
    i_page <= pg;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    res = 0;
    for (n = 0; n < 20000 && res == 0; n++)
    begin
      @(posedge i_clk);
      #1 res = {o_timeout, o_done};
    end
    if (res == 0)
    begin
      err_total++;
      $display("ERROR wait expected 1 seen 0");
      end_of_test();
    end
  endtask
  task automatic chk_page(input logic [8:0] pg);
    for (int i = 0; i < 64; i += 21) check("byte", dev.mem[{pg, 6'(i)}], 6'(i) ^ pat);
  endtask
  task automatic t_program;
    pat = 8'h3C;
    run_op(3'h0, 1'b0, 9'h005);
    check("poll done", res, 2'h1);
    chk_page(9'h005);
    pat = 8'hC3;
    run_op(3'h0, 1'b1, 9'h009);
    check("toggle done", res, 2'h1);
    chk_page(9'h009);
    $display("program test done");
  endtask
  task automatic t_protect;
    pat = 8'h5A;
    run_op(3'h2, 1'b0, 9'h002);
    check("prot on", dev.prot, 1);
    chk_page(9'h002);
    pat = 8'h96;
    run_op(3'h1, 1'b1, 9'h003);
    chk_page(9'h003);
    run_op(3'h0, 1'b0, 9'h004);
    check("blocked", dev.mem[{9'h004, 6'h00}], 8'hFF);
    pat = 8'h69;
    run_op(3'h3, 1'b0, 9'h004);
    check("prot off", dev.prot, 0);
    chk_page(9'h004);
    $display("protect test done");
  endtask
  task automatic t_erase;
    for (int t = 0; t < 2; t++)
    begin
      run_op(3'h4, t[0], 9'h000);
      check("erase done", res, 2'h1);
      check("erased", dev.mem[{9'h005, 6'h3F}], 8'hFF);
      check("erased", dev.mem[{9'h009, 6'h00}], 8'hFF);
    end
    $display("erase test done");
  endtask
  task automatic t_timeout;
    busy_cyc = 3000;
    pat = 8'h11;
    run_op(3'h0, 1'b0, 9'h007);
    check("timeout", res, 2'h2);
    $display("timeout test done");
  endtask
  initial
  begin
    {i_reset, i_start, i_use_toggle, i_op, i_page, pat} = {1'b1, 22'h0};
    busy_cyc = 300;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1 check("idle pins", {o_ready, o_ce_n, o_oe_n, o_we_n, o_dq_oe_n, o_done}, 6'h3E);
    t_program();
    t_protect();
    t_erase();
    t_timeout();
    end_of_test();
  end
endmodule // pfp_host_tb_top
`default_nettype wire
